// ==== shared/sch_pkg.sv ====
/*
 * Constants, register map and control layout of the synchronous serial
 * channel. Assumes a 16-bit register port addressed by word index.
 */
package sch_pkg;

    // ------------------------------------------------------------------
    // Sizes and rates
    // ------------------------------------------------------------------
    localparam int DW = 16;
    localparam int AW = 4;
    localparam int LEN_MIN = 2;
    localparam int LEN_MAX = 16;
    localparam int MCLK_HZ = 100_000_000;
    // Reference figures: module clock and the rate span it gives
    localparam int REF_HZ = 40_000_000;
    localparam int REF_MAX_BPS = 20_000_000;
    localparam int REF_MIN_MBPS = 305_180; // Milli-bit per second
    // Reload for the fastest rate: half the module clock
    localparam logic [15:0] BR_FASTEST = 16'(REF_HZ / (2 * REF_MAX_BPS) - 1);

    // ------------------------------------------------------------------
    // Register word indices
    // ------------------------------------------------------------------
    localparam logic [3:0] ADR_CTRL = 4'h0;
    localparam logic [3:0] ADR_BAUD = 4'h1;
    localparam logic [3:0] ADR_TX = 4'h2;
    localparam logic [3:0] ADR_RX = 4'h3;
    localparam logic [3:0] ADR_STAT = 4'h4;

    // ------------------------------------------------------------------
    // Status bit positions and reset values
    // ------------------------------------------------------------------
    localparam int ST_TXF = 0;
    localparam int ST_RXF = 1;
    localparam int ST_BUSY = 2;
    localparam int ST_ERR = 4; // te, re, pe, be in bits 4..7
    localparam logic [15:0] CTRL_RST = 16'h0007;
    localparam logic [15:0] BAUD_RST = 16'h0000;

    typedef struct packed {
        logic en;        // Channel enable
        logic ms;        // Master when set
        logic lb;        // Internal loop-back
        logic hd;        // Half-duplex, one shared data line
        logic swap;      // Exchange the two data pins
        logic hdtx;      // Half-duplex: drive the line
        logic [2:0] rsv;
        logic ph;        // Shift on leading edge when set
        logic po;        // Idle level of the shift clock
        logic msb;       // MSB first when set
        logic [3:0] lenm1; // Character length minus one, 0 also gives 2
    } sch_ctrl_t;

endpackage : sch_pkg

// ==== verilog/sch_baud.sv ====
/*
 * Baud rate divider: one-cycle tick every reload+1 module clocks.
 * Assumes en is low between transfers so each transfer starts aligned.
 */
`timescale 1ns/1ps
`default_nettype none

module sch_baud #(
    parameter int W = 16
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic en,
    input wire logic [W-1:0] reload,
    output logic tick
);

    logic [W-1:0] cnt_q;

    // Count up to the reload value, then wrap
    always_ff @(posedge mclk) begin
        if (rst || !en) begin
            cnt_q <= '0;
        end else if (cnt_q == reload) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    assign tick = en && (cnt_q == reload); // RULE17

endmodule : sch_baud

`default_nettype wire

// ==== verilog/sch_channel.sv ====
/*
 * Synchronous serial channel: master or slave shift engine, register
 * port, error detectors and three event outputs.
 * Assumes the pins are asynchronous to mclk and a slave shift clock
 * well below a quarter of mclk.
 */
// Behaviour
// (RULE1) Master drives the shift clock; slave shifts with the external clock.
// (RULE2) Character length programmable from 2 to 16 bits.
// (RULE3) Each character goes LSB first or MSB first as selected.
// (RULE4) Shift clock idle level selectable low or high.
// (RULE5) Phase selects shift edge; latching uses the other edge.
// (RULE6) Full-duplex on two lines or half-duplex on one shared line.
// (RULE7) Baud generator spans half module clock down to 1/131072 of it.
// (RULE8) Separate transmit, receive and error event outputs.
// (RULE9) Transmit event when buffer empties, receive event when it fills.
// (RULE10) Buffer misuse errors flagged and reported on the error output.
// (RULE11) Phase and baud errors on incoming data flagged and reported.
// (RULE12) Loop-back feeds transmitted bits straight into the receiver.
// (RULE13) Clock plus two data lines, data pin roles configurable.
// (RULE14) Settings allow plain SPI operation toward peripherals.
// (RULE15) Reception into an unread buffer flags error and overwrites.
// (RULE16) Slave start without new data flags error and resends old data.
// (RULE17) Master clock is mclk divided by two times reload plus one.
`timescale 1ns/1ps
`default_nettype none

module sch_channel (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    input wire logic sclk_i,
    output logic sclk_o,
    output logic sclk_oe,
    input wire logic pin_a_i,
    output logic pin_a_o,
    output logic pin_a_oe,
    input wire logic pin_b_i,
    output logic pin_b_o,
    output logic pin_b_oe,
    output logic irq_tx,
    output logic irq_rx,
    output logic irq_err
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [4:0] chlen(input logic [3:0] m1);
        return (m1 == 4'h0) ? 5'h02 : {1'b0, m1} + 5'h01;
    endfunction : chlen

    // Position of the n-th bit on the line
    function automatic logic [3:0] bidx(input logic [4:0] n,
                                        input logic [4:0] len,
                                        input logic msb);
        return msb ? 4'(len - n - 5'h01) : n[3:0]; // RULE3
    endfunction : bidx

    function automatic logic [15:0] put(input logic [15:0] v,
                                        input logic [3:0] i,
                                        input logic b);
        logic [15:0] r;
        r = v;
        r[i] = b;
        return r;
    endfunction : put

    function automatic logic [15:0] lmask(input logic [4:0] len);
        logic [16:0] m;
        m = (17'h00001 << len) - 17'h00001;
        return m[15:0];
    endfunction : lmask

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    sch_pkg::sch_ctrl_t ctrl_q;
    logic [15:0] baud_q, txbuf_q, rxbuf_q, txsh_q, rxsh_q;
    logic tx_full_q, rx_full_q, busy_q, sclk_q, dout_q, done_q;
    logic [3:0] err_q, err_set;
    logic [4:0] bitn_q, bitn_nx, len;
    logic [2:0] sy1_q, sy2_q;
    logic sck3_q, pc_q, ps_q, tick;
    logic [17:0] gap_q, gap_lim;
    logic [15:0] hcnt_q;
    logic [5:0] ecnt_q;
    logic [15:0] txsrc;
    logic m_edge, s_edge, lvl, edge_e, lead, trail, start_m, start_s;
    logic act, lat, shf, fin, a_is_out, din, drv, be_set, pe_set;
    logic wr_ctrl, wr_baud, wr_tx, wr_stat, rd_rx;

    assign len = chlen(ctrl_q.lenm1); // RULE2
    assign wr_ctrl = wr && (addr == sch_pkg::ADR_CTRL);
    assign wr_baud = wr && (addr == sch_pkg::ADR_BAUD);
    assign wr_tx = wr && (addr == sch_pkg::ADR_TX);
    assign wr_stat = wr && (addr == sch_pkg::ADR_STAT);
    assign rd_rx = rd && (addr == sch_pkg::ADR_RX);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // Two stages, third stage only for slave clock edge detection
    always_ff @(posedge mclk) begin
        if (rst) begin
            sy1_q <= 3'h0;
            sy2_q <= 3'h0;
            sck3_q <= 1'b0;
        end else begin
            sy1_q <= {sclk_i, pin_b_i, pin_a_i};
            sy2_q <= sy1_q;
            sck3_q <= sy2_q[2];
        end
    end

    // Master clocks from the divider, slave from the pin
    sch_baud #(.W(16)) u_baud (
        .mclk(mclk),
        .rst(rst),
        .en(busy_q && ctrl_q.ms),
        .reload(baud_q),
        .tick(tick)
    ); // RULE7

    // ------------------------------------------------------------------
    // Edge classification
    // ------------------------------------------------------------------
    assign m_edge = busy_q && ctrl_q.ms && tick; // RULE1
    assign s_edge = ctrl_q.en && !ctrl_q.ms && (sy2_q[2] != sck3_q); // RULE1
    assign lvl = ctrl_q.ms ? ~sclk_q : sy2_q[2];
    assign edge_e = m_edge || s_edge;
    assign lead = edge_e && (lvl != ctrl_q.po);
    assign trail = edge_e && (lvl == ctrl_q.po);
    assign start_m = ctrl_q.en && ctrl_q.ms && !busy_q && tx_full_q;
    // Slave wakes on a leading edge; a stray trailing edge is ignored
    assign start_s = s_edge && lead && !busy_q;
    assign act = (busy_q && edge_e) || start_s;
    assign lat = act && (ctrl_q.ph ? trail : lead); // RULE5
    assign shf = act && (ctrl_q.ph ? lead : trail); // RULE5
    assign bitn_nx = bitn_q + {4'h0, lat};
    assign fin = act && trail && (bitn_nx == len);
    assign txsrc = busy_q ? txsh_q : txbuf_q;

    // Data pin roles: master sends on A, slave on B, swap exchanges them
    assign a_is_out = ctrl_q.ms ^ ctrl_q.swap; // RULE13 RULE14
    // Half-duplex listens on its own output pin
    assign din = ctrl_q.lb ? dout_q :
                 ((a_is_out ^ ctrl_q.hd) ? sy2_q[1] : sy2_q[0]); // RULE6 RULE12
    assign drv = ctrl_q.en && (!ctrl_q.hd || ctrl_q.hdtx); // RULE6

    // ------------------------------------------------------------------
    // Link error detectors
    // ------------------------------------------------------------------
    // Slack of twice the half period covers synchroniser jitter
    assign gap_lim = {1'b0, baud_q, 1'b0} + 18'h00002;
    assign be_set = busy_q && !ctrl_q.ms && (gap_q == gap_lim); // RULE11
    assign pe_set = pc_q && (din != ps_q); // RULE11

    always_ff @(posedge mclk) begin
        if (rst || !busy_q || edge_e) begin
            gap_q <= 18'h00000;
        end else begin
            gap_q <= gap_q + 18'h00001;
        end
    end

    // Slave data must still be stable one cycle after the latch edge
    always_ff @(posedge mclk) begin
        if (rst) begin
            pc_q <= 1'b0;
            ps_q <= 1'b0;
        end else begin
            pc_q <= lat && !ctrl_q.ms && !ctrl_q.lb;
            ps_q <= din;
        end
    end

    assign err_set = {be_set, pe_set,
                      done_q && rx_full_q, // RULE15
                      start_s && !tx_full_q}; // RULE16 RULE10

    // ------------------------------------------------------------------
    // Shift engine
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            busy_q <= 1'b0;
            bitn_q <= 5'h00;
            txsh_q <= 16'h0000;
            rxsh_q <= 16'h0000;
            dout_q <= 1'b0;
            sclk_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= fin && !be_set;
            if (!ctrl_q.en || be_set) begin
                busy_q <= 1'b0; // Baud error aborts the character
                bitn_q <= 5'h00;
                sclk_q <= ctrl_q.po;
            end else if (start_m) begin
                busy_q <= 1'b1;
                txsh_q <= txbuf_q;
                rxsh_q <= 16'h0000;
                bitn_q <= 5'h00;
                // Fresh first bit: the idle copy may predate the last write
                dout_q <= txbuf_q[bidx(5'h00, len, ctrl_q.msb)]; // RULE3
            end else if (act) begin
                busy_q <= !fin;
                if (start_s) begin
                    txsh_q <= txbuf_q; // RULE16
                end
                if (m_edge) begin
                    sclk_q <= ~sclk_q; // RULE1
                end
                if (lat) begin
                    rxsh_q <= put(start_s ? 16'h0000 : rxsh_q,
                                  bidx(bitn_q, len, ctrl_q.msb), din);
                end
                bitn_q <= fin ? 5'h00 : bitn_nx;
                if (shf && !fin) begin
                    dout_q <= txsrc[bidx(bitn_q, len, ctrl_q.msb)];
                end
            end else if (!busy_q) begin
                sclk_q <= ctrl_q.po; // RULE4
                // First bit waits on the line before the first edge
                dout_q <= txbuf_q[bidx(5'h00, len, ctrl_q.msb)];
            end
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl_q <= sch_pkg::CTRL_RST;
            baud_q <= sch_pkg::BAUD_RST;
            txbuf_q <= 16'h0000;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= wdata;
            end
            if (wr_baud) begin
                baud_q <= wdata;
            end
            if (wr_tx) begin
                txbuf_q <= wdata;
            end
        end
    end

    // Buffer flags: the set wins over a clear in the same cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            tx_full_q <= 1'b0;
            rx_full_q <= 1'b0;
            rxbuf_q <= 16'h0000;
            err_q <= 4'h0;
        end else begin
            if (wr_tx) begin
                tx_full_q <= 1'b1;
            end else if (start_m || start_s) begin
                tx_full_q <= 1'b0;
            end
            if (done_q) begin
                rx_full_q <= 1'b1;
                rxbuf_q <= rxsh_q; // RULE15
            end else if (rd_rx) begin
                rx_full_q <= 1'b0;
            end
            err_q <= err_set | (err_q &
                     ~(wr_stat ? wdata[sch_pkg::ST_ERR +: 4] : 4'h0));
        end
    end

    // Read data for one cycle only; unmapped words read zero
    always_ff @(posedge mclk) begin
        if (rst || !rd) begin
            rdata <= 16'h0000;
        end else if (addr == sch_pkg::ADR_CTRL) begin
            rdata <= ctrl_q;
        end else if (addr == sch_pkg::ADR_BAUD) begin
            rdata <= baud_q;
        end else if (addr == sch_pkg::ADR_TX) begin
            rdata <= txbuf_q;
        end else if (addr == sch_pkg::ADR_RX) begin
            rdata <= rxbuf_q;
        end else if (addr == sch_pkg::ADR_STAT) begin
            rdata <= {8'h00, err_q, 1'b0, busy_q, rx_full_q, tx_full_q};
        end else begin
            rdata <= 16'h0000;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Clock and data both pass one flop, so their alignment is kept
    always_ff @(posedge mclk) begin
        if (rst) begin
            sclk_o <= 1'b0;
            sclk_oe <= 1'b0;
            pin_a_o <= 1'b0;
            pin_a_oe <= 1'b0;
            pin_b_o <= 1'b0;
            pin_b_oe <= 1'b0;
            irq_tx <= 1'b0;
            irq_rx <= 1'b0;
            irq_err <= 1'b0;
        end else begin
            sclk_o <= sclk_q;
            sclk_oe <= ctrl_q.en && ctrl_q.ms; // RULE1
            pin_a_o <= dout_q;
            pin_a_oe <= drv && a_is_out; // RULE13
            pin_b_o <= dout_q;
            pin_b_oe <= drv && !a_is_out; // RULE13
            irq_tx <= start_m || start_s; // RULE9 RULE8
            irq_rx <= done_q; // RULE9 RULE8
            irq_err <= |err_set; // RULE10 RULE11 RULE8
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // Helper counters for master timing
    always_ff @(posedge mclk) begin
        if (rst || start_m || m_edge || !busy_q) begin
            hcnt_q <= 16'h0000;
        end else begin
            hcnt_q <= hcnt_q + 16'h0001;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst || start_m) begin
            ecnt_q <= 6'h00;
        end else if (m_edge) begin
            ecnt_q <= ecnt_q + 6'h01;
        end
    end

    half_period_a: assert property (m_edge |-> hcnt_q == baud_q) // RULE17
        else $error("master half period differs from reload plus one");
    char_len_a: assert property (fin && ctrl_q.ms |-> // RULE2
        ecnt_q + 6'h01 == {len, 1'b0})
        else $error("master character edge count wrong");
    tx_empty_a: assert property ((start_m || start_s) |=> // RULE9
        irq_tx && (txsh_q == $past(txbuf_q)))
        else $error("transmit event missing at buffer take");
    rx_full_a: assert property (done_q |=> // RULE9
        irq_rx && rx_full_q && (rxbuf_q == $past(rxsh_q)))
        else $error("receive buffer not loaded with event");
    rx_over_a: assert property (done_q && rx_full_q |=> // RULE15
        err_q[1] && irq_err)
        else $error("overrun not flagged");
    tx_under_a: assert property (start_s && !tx_full_q |=> // RULE16
        err_q[0] && irq_err)
        else $error("slave underrun not flagged");
    baud_err_a: assert property (be_set |=> // RULE11
        !busy_q && err_q[3] ##1 !irq_rx)
        else $error("baud error did not abort");
    idle_level_a: assert property (!busy_q && ctrl_q.en && !start_m // RULE4
        |=> sclk_q == $past(ctrl_q.po))
        else $error("idle clock level wrong");
    loop_data_a: assert property (done_q && ctrl_q.lb && ctrl_q.ms // RULE12
        && $stable(ctrl_q) |-> ((rxsh_q ^ txsh_q) & lmask(len)) == 16'h0000)
        else $error("loop-back data mismatch");
    pin_role_a: assert property (ctrl_q.en && !ctrl_q.hd // RULE13
        && $stable(ctrl_q) |=> pin_a_oe != pin_b_oe)
        else $error("data pin roles not exclusive");
    irq_pulse_a: assert property (irq_tx |=> !irq_tx) // RULE8
        else $error("transmit event longer than one cycle");

endmodule : sch_channel

`default_nettype wire

// ==== verif/sch_slave_model.sv ====
/*
 * Peripheral on the far side of the channel in master mode: a shift
 * register that answers on the master-in line.
 * Assumes sclk comes from the channel and arm is pulsed before a frame.
 */
`timescale 1ns/1ps
`default_nettype none

module sch_slave_model (
    input wire logic sclk,
    input wire logic mosi,
    input wire logic po,
    input wire logic ph,
    input wire logic msb,
    input wire logic [4:0] len,
    input wire logic arm,
    input wire logic [15:0] tx_word,
    output logic miso,
    output logic [15:0] rx_word
);
    int cnt = 32;

    // Next outgoing bit in the chosen order
    function automatic logic pick(input int i);
        return msb ? tx_word[len - 1 - i] : tx_word[i];
    endfunction : pick

    // ------------------------------------------------------------------
    // Frame arming: first bit must stand before the first edge
    // ------------------------------------------------------------------
    initial miso = 1'b0;
    always @(posedge arm) begin
        cnt = 0;
        rx_word = 16'h0000;
        miso = pick(0);
    end

    // Shift on one edge, latch on the other, with the master's clock
    always @(sclk) begin
        if (cnt < int'(len)) begin
            if ((sclk !== po) ^ ph) begin
                if (msb) rx_word[len - 1 - cnt] = mosi;
                else rx_word[cnt] = mosi;
                cnt++;
                // Line inverted after the last bit: do not keep the value
                if (cnt == int'(len)) miso = ~miso;
            end else begin
                miso = pick(cnt);
            end
        end
    end
endmodule : sch_slave_model

`default_nettype wire

// ==== verif/sch_channel_test.sv ====
/*
 * Self-checking bench of the serial channel in master and slave mode.
 * Assumes the register map and control layout of sch_pkg.
 */
`timescale 1ns/1ps
`default_nettype none

module sch_channel_test;
    logic mclk, rst, wr, rd, arm, po, ph, msb, miso;
    logic [3:0] addr;
    logic [15:0] wdata, rdata, rval, slv_tx, slv_rx;
    logic sclk_o, sclk_oe, pin_a_o, pin_a_oe, pin_b_o, pin_b_oe;
    logic irq_tx, irq_rx, irq_err;
    logic [4:0] len;
    int bad_count, cmp_count, ntx, nrx, nerr, half;
    wire logic sclk_w, a_w, b_w;

    // ------------------------------------------------------------------
    // Pin levels resolved from the channel's output enables
    // ------------------------------------------------------------------
    assign sclk_w = sclk_oe ? sclk_o : po;
    assign a_w = pin_a_oe ? pin_a_o : 1'b1;
    assign b_w = pin_b_oe ? pin_b_o : miso;

    sch_channel uut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .sclk_i(sclk_w), .sclk_o(sclk_o),
        .sclk_oe(sclk_oe), .pin_a_i(a_w), .pin_a_o(pin_a_o),
        .pin_a_oe(pin_a_oe), .pin_b_i(b_w), .pin_b_o(pin_b_o),
        .pin_b_oe(pin_b_oe), .irq_tx(irq_tx), .irq_rx(irq_rx),
        .irq_err(irq_err));

    sch_slave_model peer (.sclk(sclk_w), .mosi(a_w), .po(po), .ph(ph),
        .msb(msb), .len(len), .arm(arm), .tx_word(slv_tx), .miso(miso),
        .rx_word(slv_rx));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic conclude;
        if (bad_count == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : conclude

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1 rval = rdata;
    endtask : rd_reg

    // One character with the peer; counts events and the clock half period
    task automatic run(input logic [15:0] ctrl, input logic [15:0] tx,
                       input logic [15:0] stx);
        logic last;
        int t0;
        po = ctrl[5];
        ph = ctrl[6];
        msb = ctrl[4];
        len = 5'(ctrl[3:0]) + 5'd1;
        slv_tx = stx;
        wr_reg(sch_pkg::ADR_CTRL, ctrl);
        // New idle level reaches the pin two cycles after the write
        repeat (2) @(posedge mclk);
        #1;
        check("idle clock", {15'h0, sclk_o}, {15'h0, ctrl[5]});
        check("clock drive", {15'h0, sclk_oe}, 16'h0001);
        // Arm once the clock is settled, else a polarity swap counts as edge
        arm = 1'b1;
        @(posedge mclk);
        arm = 1'b0;
        wr_reg(sch_pkg::ADR_TX, tx);
        ntx = 0;
        nrx = 0;
        nerr = 0;
        half = 0;
        t0 = 0;
        last = sclk_o;
        for (int i = 1; i < 3000 && nrx == 0; i++) begin
            @(posedge mclk);
            #1;
            if (sclk_o !== last) begin
                if (t0 > 0 && half == 0) half = i - t0;
                t0 = i;
                last = sclk_o;
            end
            ntx += int'(irq_tx === 1'b1);
            nrx += int'(irq_rx === 1'b1);
            nerr += int'(irq_err === 1'b1);
        end
        if (nrx == 0) begin
            bad_count++;
            conclude();
        end
        check("tx events", 16'(ntx), 16'h0001);
        check("half period", 16'(half), 16'h0005);
        check("end idle", {15'h0, sclk_o}, {15'h0, ctrl[5]});
        if (!ctrl[13]) begin
            check("peer rx", slv_rx, tx & (16'hffff >> (16 - len)));
        end
    endtask : run

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic s_reset;
        rd_reg(sch_pkg::ADR_CTRL);
        check("ctrl reset", rval, sch_pkg::CTRL_RST);
        rd_reg(sch_pkg::ADR_BAUD);
        check("baud reset", rval, sch_pkg::BAUD_RST);
        rd_reg(sch_pkg::ADR_STAT);
        check("status reset", rval, 16'h0000);
        wr_reg(4'hf, 16'hffff);
        rd_reg(4'hf);
        check("unmapped", rval, 16'h0000);
        check("slave clock", {15'h0, sclk_oe}, 16'h0000);
    endtask : s_reset

    // Eight bits LSB first, shift on trailing edge
    task automatic s_master;
        wr_reg(sch_pkg::ADR_BAUD, 16'h0004);
        run(16'hc007, 16'h5a3c, 16'h00a5);
        rd_reg(sch_pkg::ADR_RX);
        check("rx lsb", rval, 16'h00a5);
        rd_reg(sch_pkg::ADR_STAT);
        check("rx drained", {15'h0, rval[1]}, 16'h0000);
    endtask : s_master

    // Longest character, MSB first, idle high, shift on leading edge
    task automatic s_msb16;
        run(16'hc07f, 16'h8001, 16'h4c37);
        rd_reg(sch_pkg::ADR_RX);
        check("rx msb", rval, 16'h4c37);
    endtask : s_msb16

    // Second character lands on an unread one
    task automatic s_overrun;
        run(16'hc047, 16'h0011, 16'h0022);
        run(16'hc047, 16'h0033, 16'h0044);
        check("err events", 16'(nerr), 16'h0001);
        rd_reg(sch_pkg::ADR_STAT);
        check("overrun flags", {12'h0, rval[7:4]}, 16'h0002);
        rd_reg(sch_pkg::ADR_RX);
        check("overwritten", rval, 16'h0044);
        wr_reg(sch_pkg::ADR_STAT, 16'h00f0);
        rd_reg(sch_pkg::ADR_STAT);
        check("flags cleared", {12'h0, rval[7:4]}, 16'h0000);
    endtask : s_overrun

    // Shortest character fed back internally
    task automatic s_loop;
        run(16'he001, 16'h0002, 16'h0001);
        rd_reg(sch_pkg::ADR_RX);
        check("loop rx", rval, 16'h0002);
    endtask : s_loop

    // Slave without fresh data: old word resent, pull-up ones received
    task automatic s_slave;
        logic [15:0] got;
        got = 16'h0000;
        wr_reg(sch_pkg::ADR_CTRL, 16'h8007);
        ntx = 0;
        nrx = 0;
        nerr = 0;
        // Bench clock on the idle line, half period of 8 cycles
        for (int i = 1; i < 200 && nrx == 0; i++) begin
            @(posedge mclk);
            #1;
            if (i % 8 == 0 && i <= 128) begin
                if (!po) got[i / 16] = b_w;
                po = ~po;
            end
            ntx += int'(irq_tx === 1'b1);
            nrx += int'(irq_rx === 1'b1);
            nerr += int'(irq_err === 1'b1);
        end
        check("slave done", 16'(nrx), 16'h0001);
        check("slave tx events", 16'(ntx), 16'h0001);
        check("slave tx", got, 16'h0002);
        check("slave err events", 16'(nerr), 16'h0001);
        rd_reg(sch_pkg::ADR_STAT);
        check("underrun flag", {12'h0, rval[7:4]}, 16'h0001);
        rd_reg(sch_pkg::ADR_RX);
        check("slave rx", rval, 16'h00ff);
    endtask : s_slave

    // ------------------------------------------------------------------
    // Clock, reset and sequence
    // ------------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial begin
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 4'h0;
        wdata = 16'h0000;
        arm = 1'b0;
        po = 1'b0;
        ph = 1'b0;
        msb = 1'b0;
        len = 5'h08;
        slv_tx = 16'h0000;
        bad_count = 0;
        cmp_count = 0;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        s_reset();
        s_master();
        s_msb16();
        s_overrun();
        s_loop();
        s_slave();
        conclude();
    end
endmodule : sch_channel_test

`default_nettype wire
